/* File: design/rcf_top.sv */
// Purpose: Reset cause flag register with sticky event interrupt
// Assumes: Event inputs are one-cycle pulses from logic on clk_i
// Notes: Power-on reset is resetn_i; flags hold value until written
`timescale 1ns/10ps
`default_nettype none
module rcf_top
  import rcf_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Reset cause events
  input wire logic cfg_mismatch_i,
  input wire logic ext_pin_i,
  input wire logic software_i,
  input wire logic watchdog_i,
  input wire logic wake_sleep_i,
  input wire logic wake_idle_i,
  input wire logic brownout_i,
  // Outputs
  output logic regulator_standby_enable_o,
  output logic irq_o
);
  // ==========================================================
  // Bundles
  rcf_event_type ev;
  rcf_bus_type bus;
  assign ev = '{cfg_mismatch: cfg_mismatch_i, ext_pin: ext_pin_i, software: software_i,
                watchdog: watchdog_i, wake_sleep: wake_sleep_i, wake_idle: wake_idle_i,
                brownout: brownout_i, power_on: 1'b0};
  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // ==========================================================
  // Decode
  wire sel_cause = (bus.addr == RCF_OFS_CAUSE);
  wire sel_stat = (bus.addr == RCF_OFS_IRQ_STAT);
  wire sel_mask = (bus.addr == RCF_OFS_IRQ_MASK);
  wire wr_cause = bus.wr && sel_cause;
  wire wr_stat = bus.wr && sel_stat;
  wire wr_mask = bus.wr && sel_mask;

  // ==========================================================
  // Cause register
  logic [31:0] set_vec;
  logic [31:0] cause;
  logic [31:0] cause_prev_q;
  logic vreg_q;
  assign set_vec = RCF_ZERO
    | ({31'h0, ev.cfg_mismatch} << RCF_BIT_CMR)
    | ({31'h0, ev.ext_pin} << RCF_BIT_EXT)
    | ({31'h0, ev.software} << RCF_BIT_SW)
    | ({31'h0, ev.watchdog} << RCF_BIT_WDT)
    | ({31'h0, ev.wake_sleep} << RCF_BIT_SLEEP)
    | ({31'h0, ev.wake_idle} << RCF_BIT_IDLE)
    | ({31'h0, ev.brownout} << RCF_BIT_BOR)
    | ({31'h0, ev.power_on} << RCF_BIT_POR);

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_flag
      if (RCF_FLAG_MASK[gi]) begin : g_impl
        rcf_flag_bit #(
          .RESET_VAL(RCF_CAUSE_RST[gi])
        ) u_flag (
          .clk_i(clk_i),
          .resetn_i(resetn_i),
          .set_i(set_vec[gi]),
          .wr_i(wr_cause),
          .wval_i(bus.wdata[gi]),
          .flag_o(cause[gi])
        );
      end else if (gi == RCF_BIT_VREG) begin : g_vreg
        assign cause[gi] = vreg_q;
      end else begin : g_none
        assign cause[gi] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      vreg_q <= 1'b0;
    end else if (wr_cause) begin
      vreg_q <= bus.wdata[RCF_BIT_VREG];
    end
  end

  // ==========================================================
  // Interrupt status and mask
  logic [31:0] new_set;
  logic [31:0] istat_q;
  logic [31:0] istat_d;
  logic [31:0] imask_q;
  logic irq_q;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cause_prev_q <= RCF_CAUSE_RST;
    end else begin
      cause_prev_q <= cause;
    end
  end
  assign new_set = cause & ~cause_prev_q & RCF_FLAG_MASK;
  assign istat_d = (istat_q & ~(wr_stat ? bus.wdata : RCF_ZERO)) | new_set;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      istat_q <= RCF_ZERO;
      imask_q <= RCF_ZERO;
      irq_q <= 1'b0;
    end else begin
      istat_q <= istat_d;
      imask_q <= wr_mask ? (bus.wdata & RCF_FLAG_MASK) : imask_q;
      irq_q <= |(istat_d & (wr_mask ? (bus.wdata & RCF_FLAG_MASK) : imask_q));
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe
  wire [31:0] rd_mux = sel_cause ? (cause & RCF_IMPL_MASK) :
                       sel_stat ? istat_q :
                       sel_mask ? imask_q : RCF_ZERO;
  logic [31:0] rdata_q;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_q <= RCF_ZERO;
    end else begin
      rdata_q <= bus.rd ? rd_mux : RCF_ZERO;
    end
  end
  assign rdata_o = rdata_q;
  assign regulator_standby_enable_o = vreg_q;
  assign irq_o = irq_q;

  // ==========================================================
  // Checks: event sequences, an event that finds its flag clear, and a flag rise
  sequence s_cmr_evt;
    cfg_mismatch_i && !cause[RCF_BIT_CMR];
  endsequence
  sequence s_ext_evt;
    ext_pin_i && !cause[RCF_BIT_EXT];
  endsequence
  sequence s_sw_evt;
    software_i && !cause[RCF_BIT_SW];
  endsequence
  sequence s_wd_evt;
    watchdog_i && !cause[RCF_BIT_WDT];
  endsequence
  sequence s_sleep_evt;
    wake_sleep_i && !cause[RCF_BIT_SLEEP];
  endsequence
  sequence s_idle_evt;
    wake_idle_i && !cause[RCF_BIT_IDLE];
  endsequence
  sequence s_bor_evt;
    brownout_i && !cause[RCF_BIT_BOR];
  endsequence
  sequence s_flag_rise(int b);
    cause[b] && !cause_prev_q[b];
  endsequence

  // ==========================================================
  // Checks: hardware sets, vreg write, flag hold, reserved bits and cause read
  cmr_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cfg_mismatch_i |=> cause[RCF_BIT_CMR])
    else $error("mismatch flag not set");
  vreg_wr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_cause |=> regulator_standby_enable_o == $past(wdata_i[RCF_BIT_VREG]))
    else $error("vreg wrong");
  ext_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ext_pin_i |=> cause[RCF_BIT_EXT])
    else $error("ext flag not set");
  sw_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    software_i |=> cause[RCF_BIT_SW])
    else $error("sw flag not set");
  wdt_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_wd_evt |=> cause[RCF_BIT_WDT] ##1 istat_q[RCF_BIT_WDT])
    else $error("wdt flag or status lost");
  sleep_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wake_sleep_i |=> cause[RCF_BIT_SLEEP])
    else $error("sleep flag not set");
  idle_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wake_idle_i |=> cause[RCF_BIT_IDLE])
    else $error("idle flag not set");
  bor_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    brownout_i |=> cause[RCF_BIT_BOR])
    else $error("brownout flag not set");
  por_after_a: assert property (@(posedge clk_i)
    $rose(resetn_i) |-> cause[RCF_BIT_POR] && cause[RCF_BIT_BOR])
    else $error("por flags low");
  flag_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !wr_cause && (set_vec == RCF_ZERO) |=> cause == $past(cause))
    else $error("flag changed");
  rsvd_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (cause & ~RCF_IMPL_MASK) == RCF_ZERO)
    else $error("reserved bit set");
  rdata_time_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_i && addr_i == RCF_OFS_CAUSE |=> rdata_o == ($past(cause) & RCF_IMPL_MASK))
    else $error("bad read");

  // ==========================================================
  // Checks: event to status in two cycles
  cmr_stat_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_cmr_evt |=> cause[RCF_BIT_CMR] ##1 istat_q[RCF_BIT_CMR])
    else $error("mismatch status lost");
  ext_stat_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_ext_evt |=> cause[RCF_BIT_EXT] ##1 istat_q[RCF_BIT_EXT])
    else $error("ext status lost");
  sw_stat_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_sw_evt |=> cause[RCF_BIT_SW] ##1 istat_q[RCF_BIT_SW])
    else $error("sw status lost");
  sleep_stat_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_sleep_evt |=> cause[RCF_BIT_SLEEP] ##1 istat_q[RCF_BIT_SLEEP])
    else $error("sleep status lost");
  idle_stat_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_idle_evt |=> cause[RCF_BIT_IDLE] ##1 istat_q[RCF_BIT_IDLE])
    else $error("idle status lost");
  bor_stat_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_bor_evt |=> cause[RCF_BIT_BOR] ##1 istat_q[RCF_BIT_BOR])
    else $error("brownout status lost");

  // ==========================================================
  // Checks: software writes to flags, set wins otherwise
  cmr_wr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_cause && !set_vec[RCF_BIT_CMR] |=> cause[RCF_BIT_CMR] == $past(wdata_i[RCF_BIT_CMR]))
    else $error("mismatch flag write lost");
  ext_wr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_cause && !set_vec[RCF_BIT_EXT] |=> cause[RCF_BIT_EXT] == $past(wdata_i[RCF_BIT_EXT]))
    else $error("ext flag write lost");
  sw_wr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_cause && !set_vec[RCF_BIT_SW] |=> cause[RCF_BIT_SW] == $past(wdata_i[RCF_BIT_SW]))
    else $error("sw flag write lost");
  wdt_wr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_cause && !set_vec[RCF_BIT_WDT] |=> cause[RCF_BIT_WDT] == $past(wdata_i[RCF_BIT_WDT]))
    else $error("wdt flag write lost");
  sleep_wr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_cause && !set_vec[RCF_BIT_SLEEP] |=> cause[RCF_BIT_SLEEP] == $past(wdata_i[RCF_BIT_SLEEP]))
    else $error("sleep flag write lost");
  idle_wr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_cause && !set_vec[RCF_BIT_IDLE] |=> cause[RCF_BIT_IDLE] == $past(wdata_i[RCF_BIT_IDLE]))
    else $error("idle flag write lost");
  bor_wr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_cause && !set_vec[RCF_BIT_BOR] |=> cause[RCF_BIT_BOR] == $past(wdata_i[RCF_BIT_BOR]))
    else $error("brownout flag write lost");
  por_wr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_cause && !set_vec[RCF_BIT_POR] |=> cause[RCF_BIT_POR] == $past(wdata_i[RCF_BIT_POR]))
    else $error("por flag write lost");

  // ==========================================================
  // Checks: status latches every rising flag
  cmr_latch_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_flag_rise(RCF_BIT_CMR) |=> istat_q[RCF_BIT_CMR])
    else $error("mismatch status missed");
  ext_latch_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_flag_rise(RCF_BIT_EXT) |=> istat_q[RCF_BIT_EXT])
    else $error("ext status missed");
  sw_latch_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_flag_rise(RCF_BIT_SW) |=> istat_q[RCF_BIT_SW])
    else $error("sw status missed");
  wdt_latch_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_flag_rise(RCF_BIT_WDT) |=> istat_q[RCF_BIT_WDT])
    else $error("wdt status missed");
  sleep_latch_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_flag_rise(RCF_BIT_SLEEP) |=> istat_q[RCF_BIT_SLEEP])
    else $error("sleep status missed");
  idle_latch_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_flag_rise(RCF_BIT_IDLE) |=> istat_q[RCF_BIT_IDLE])
    else $error("idle status missed");
  bor_latch_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_flag_rise(RCF_BIT_BOR) |=> istat_q[RCF_BIT_BOR])
    else $error("brownout status missed");
  por_latch_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_flag_rise(RCF_BIT_POR) |=> istat_q[RCF_BIT_POR])
    else $error("por status missed");

  // ==========================================================
  // Checks: status cleared by writing one
  cmr_clr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_stat && wdata_i[RCF_BIT_CMR] && !new_set[RCF_BIT_CMR] |=> !istat_q[RCF_BIT_CMR])
    else $error("mismatch status not cleared");
  ext_clr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_stat && wdata_i[RCF_BIT_EXT] && !new_set[RCF_BIT_EXT] |=> !istat_q[RCF_BIT_EXT])
    else $error("ext status not cleared");
  sw_clr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_stat && wdata_i[RCF_BIT_SW] && !new_set[RCF_BIT_SW] |=> !istat_q[RCF_BIT_SW])
    else $error("sw status not cleared");
  wdt_clr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_stat && wdata_i[RCF_BIT_WDT] && !new_set[RCF_BIT_WDT] |=> !istat_q[RCF_BIT_WDT])
    else $error("wdt status not cleared");
  sleep_clr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_stat && wdata_i[RCF_BIT_SLEEP] && !new_set[RCF_BIT_SLEEP] |=> !istat_q[RCF_BIT_SLEEP])
    else $error("sleep status not cleared");
  idle_clr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_stat && wdata_i[RCF_BIT_IDLE] && !new_set[RCF_BIT_IDLE] |=> !istat_q[RCF_BIT_IDLE])
    else $error("idle status not cleared");
  bor_clr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_stat && wdata_i[RCF_BIT_BOR] && !new_set[RCF_BIT_BOR] |=> !istat_q[RCF_BIT_BOR])
    else $error("brownout status not cleared");
  por_clr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_stat && wdata_i[RCF_BIT_POR] && !new_set[RCF_BIT_POR] |=> !istat_q[RCF_BIT_POR])
    else $error("por status not cleared");
  stat_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !wr_stat && (new_set == RCF_ZERO) |=> istat_q == $past(istat_q))
    else $error("status changed");

  // ==========================================================
  // Checks: register port and interrupt
  rd_idle_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !rd_i |=> rdata_o == RCF_ZERO)
    else $error("read data not zero");
  stat_rd_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_i && addr_i == RCF_OFS_IRQ_STAT |=> rdata_o == $past(istat_q))
    else $error("bad status read");
  mask_rd_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_i && addr_i == RCF_OFS_IRQ_MASK |=> rdata_o == $past(imask_q))
    else $error("bad mask read");
  unmap_rd_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_i && !sel_cause && !sel_stat && !sel_mask |=> rdata_o == RCF_ZERO)
    else $error("unmapped read not zero");
  mask_wr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_mask |=> imask_q == ($past(wdata_i) & RCF_FLAG_MASK))
    else $error("mask write lost");
  mask_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !wr_mask |=> imask_q == $past(imask_q))
    else $error("mask changed");
  vreg_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !wr_cause |=> regulator_standby_enable_o == $past(regulator_standby_enable_o))
    else $error("vreg changed");
  stat_rsvd_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (istat_q & ~RCF_FLAG_MASK) == RCF_ZERO)
    else $error("reserved status bit set");
  mask_rsvd_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (imask_q & ~RCF_FLAG_MASK) == RCF_ZERO)
    else $error("reserved mask bit set");
  irq_level_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    irq_o == (|(istat_q & imask_q)))
    else $error("irq level wrong");
  rst_state_a: assert property (@(posedge clk_i)
    $rose(resetn_i) |-> istat_q == RCF_ZERO && imask_q == RCF_ZERO && !irq_o && !regulator_standby_enable_o)
    else $error("state after reset wrong");
endmodule : rcf_top
`default_nettype wire

/* File: design/rcf_pkg.sv */
// Purpose: Shared constants and types for the reset cause flag block
// Assumes: One 32-bit status register plus interrupt status and mask registers
// Notes: Function list below
//
// Function
// - The configuration-mismatch flag at bit 9 is set by a configuration mismatch reset or by a software write of one.
// - Bit 8 set keeps the regulator on during sleep; clear selects stand-by tracking mode. The code drives regulator_standby_enable_o high when bit 8 is set.
// - The external pin reset flag at bit 7 is set whenever the master clear pin causes a reset.
// - The software reset flag at bit 6 is set whenever a software reset has executed.
// - The watchdog timeout flag at bit 4 is set whenever the watchdog timer times out.
// - The sleep wake flag at bit 3 is set on waking from sleep mode.
// - The idle wake flag at bit 2 is set on waking from idle mode.
// - The brown-out flag at bit 1 is set on brown-out and reads one after power-on reset.
// - The power-on flag at bit 0 is set on power-on reset and reads one after it.
// - Cause flags are set by hardware, writable by software, and held until software writes them.
package rcf_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] RCF_OFS_CAUSE = 8'h00;
  localparam logic [7:0] RCF_OFS_IRQ_STAT = 8'h04;
  localparam logic [7:0] RCF_OFS_IRQ_MASK = 8'h08;
  // ==========================================================
  // Bit positions
  localparam int RCF_BIT_CMR = 9;
  localparam int RCF_BIT_VREG = 8;
  localparam int RCF_BIT_EXT = 7;
  localparam int RCF_BIT_SW = 6;
  localparam int RCF_BIT_WDT = 4;
  localparam int RCF_BIT_SLEEP = 3;
  localparam int RCF_BIT_IDLE = 2;
  localparam int RCF_BIT_BOR = 1;
  localparam int RCF_BIT_POR = 0;
  // ==========================================================
  // Masks and reset values
  localparam logic [31:0] RCF_FLAG_MASK = 32'h0000_02df;
  localparam logic [31:0] RCF_IMPL_MASK = 32'h0000_03df;
  localparam logic [31:0] RCF_CAUSE_RST = 32'h0000_0003;
  localparam logic [31:0] RCF_ZERO = 32'h0000_0000;
  // ==========================================================
  // Hardware event bundle
  typedef struct packed {
    logic cfg_mismatch;
    logic ext_pin;
    logic software;
    logic watchdog;
    logic wake_sleep;
    logic wake_idle;
    logic brownout;
    logic power_on;
  } rcf_event_type;
  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rcf_bus_type;
endpackage : rcf_pkg

/* File: design/rcf_flag_bit.sv */
// Purpose: One sticky flag, set by hardware, written by software
// Assumes: Set and write come from the same clock domain
// Notes: Hardware set wins over a software write of zero
`timescale 1ns/10ps
`default_nettype none
module rcf_flag_bit #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Controls
  input wire logic set_i,
  input wire logic wr_i,
  input wire logic wval_i,
  // State
  output logic flag_o
);
  logic flag_q;
  logic flag_d;
  assign flag_d = set_i ? 1'b1 : (wr_i ? wval_i : flag_q);
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      flag_q <= RESET_VAL;
    end else begin
      flag_q <= flag_d;
    end
  end
  assign flag_o = flag_q;
endmodule : rcf_flag_bit
`default_nettype wire

/* File: dv/rcf_top_tb_top.sv */
// Purpose: Self-checking bench for the reset cause flag block
// Assumes: Register port and event pulses driven on clk_i rising edges
// Notes: Each scenario is one task
`timescale 1ns/10ps
`default_nettype none
module rcf_top_tb_top;
  import rcf_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] ev = 7'h00;
  logic [31:0] rdata;
  logic reg_sb;
  logic irq;
  int failures = 0;
  int cmp_count = 0;
  // Event index to cause bit position
  int pos [7] = '{1, 2, 3, 4, 6, 7, 9};
  rcf_top u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .cfg_mismatch_i(ev[6]), .ext_pin_i(ev[5]), .software_i(ev[4]),
    .watchdog_i(ev[3]), .wake_sleep_i(ev[2]), .wake_idle_i(ev[1]), .brownout_i(ev[0]),
    .regulator_standby_enable_o(reg_sb), .irq_o(irq)
  );
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ==========================================================
  // Bus and compare tasks
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr <= a; rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd_chk
  task pulse(input logic [6:0] v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= 7'h00;
  endtask : pulse
  // ==========================================================
  // Scenarios
  task t_reset;
    rd_chk(RCF_OFS_CAUSE, RCF_CAUSE_RST);
    rd_chk(RCF_OFS_IRQ_MASK, RCF_ZERO);
    @(posedge clk_i);
    #1 chk(rdata, RCF_ZERO);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, reg_sb}, 32'h0);
  endtask : t_reset
  task t_events;
    logic [31:0] e;
    e = RCF_ZERO;
    wr_reg(RCF_OFS_CAUSE, RCF_ZERO);
    rd_chk(RCF_OFS_CAUSE, RCF_ZERO);
    for (int i = 0; i < 7; i++) begin
      pulse(7'h01 << i);
      e[pos[i]] = 1'b1;
      rd_chk(RCF_OFS_CAUSE, e);
    end
  endtask : t_events
  task t_write;
    wr_reg(RCF_OFS_CAUSE, 32'hffff_ffff);
    repeat (2) @(posedge clk_i);
    #1 chk({31'h0, reg_sb}, 32'h1);
    rd_chk(RCF_OFS_CAUSE, RCF_IMPL_MASK);
    wr_reg(RCF_OFS_CAUSE, 32'h0000_0100);
    rd_chk(RCF_OFS_CAUSE, 32'h0000_0100);
    wr_reg(RCF_OFS_CAUSE, RCF_ZERO);
    repeat (2) @(posedge clk_i);
    #1 chk({31'h0, reg_sb}, 32'h0);
    wr_reg(8'h0c, 32'hffff_ffff);
    rd_chk(8'h0c, RCF_ZERO);
  endtask : t_write
  task t_set_wins;
    @(posedge clk_i);
    addr <= RCF_OFS_CAUSE; wdata <= RCF_ZERO; wr <= 1'b1; ev <= 7'h08;
    @(posedge clk_i);
    wr <= 1'b0; ev <= 7'h00;
    rd_chk(RCF_OFS_CAUSE, 32'h0000_0010);
  endtask : t_set_wins
  task t_irq;
    wr_reg(RCF_OFS_CAUSE, RCF_ZERO);
    wr_reg(RCF_OFS_IRQ_STAT, 32'hffff_ffff);
    wr_reg(RCF_OFS_IRQ_MASK, 32'h0000_0010);
    rd_chk(RCF_OFS_IRQ_STAT, RCF_ZERO);
    pulse(7'h08);
    @(posedge clk_i);
    #1 chk({31'h0, irq}, 32'h1);
    rd_chk(RCF_OFS_IRQ_STAT, 32'h0000_0010);
    wr_reg(RCF_OFS_IRQ_STAT, 32'h0000_0010);
    pulse(7'h04);
    repeat (2) @(posedge clk_i);
    #1 chk({31'h0, irq}, 32'h0);
    rd_chk(RCF_OFS_IRQ_STAT, 32'h0000_0008);
    rd_chk(RCF_OFS_CAUSE, 32'h0000_0018);
  endtask : t_irq
  // ==========================================================
  // Verdict and run control
  task report_and_stop;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #20000;
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_events();
    t_write();
    t_set_wins();
    t_irq();
    report_and_stop();
  end
endmodule : rcf_top_tb_top
`default_nettype wire
